/* File: dv/asrc_mem_model.sv */
module asrc_mem_model (
   input wire logic sys_clk_i, // Bench clock, drives float pattern
   input wire logic select_low_n_i, // Active-low select pin
   input wire logic select_high_i, // Active-high select pin
   input wire logic oe_n_i, // Output enable pin
   input wire logic we_n_i, // Write enable pin
   input wire logic upper_byte_enable_n_i, // Upper lane enable
   input wire logic lower_byte_enable_n_i, // Lower lane enable
   input wire logic [19:0] addr_i, // Address pins
   input wire logic [15:0] dq_c_i, // Controller data value
   input wire logic dq_oe_n_i, // Controller drives when low
   input wire logic err_en_i, // Flag a corrected error
   input wire logic [7:0] err_addr_i, // Word with the flagged error
   output logic [15:0] bus_o, // Resolved data pin level
   output logic err_o, // Error flag pin
   output logic mem_drv_o // Memory drives some lane
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:255];
   logic [15:0] word;
   logic [15:0] float_q = 16'h5a5a;
   logic sel, rd, rd_hi, rd_lo, rd_hi_d, rd_lo_d, hi_on, lo_on;
   // ---------------------------------------------------------------
   // Read side
   // ---------------------------------------------------------------
   assign sel = !select_low_n_i && select_high_i;
   assign rd = sel && !oe_n_i && we_n_i;
   assign rd_hi = rd && !upper_byte_enable_n_i;
   assign rd_lo = rd && !lower_byte_enable_n_i;
   // Lanes float at once but turn on late, so no overlap
   assign #4 rd_hi_d = rd_hi;
   assign #4 rd_lo_d = rd_lo;
   assign hi_on = rd_hi && rd_hi_d;
   assign lo_on = rd_lo && rd_lo_d;
   assign #8 word = mem[addr_i[7:0]];
   assign #8 err_o = rd && err_en_i && addr_i[7:0] == err_addr_i;
   assign mem_drv_o = hi_on || lo_on;
   // Released lanes change every cycle rather than keep their value
   always @(posedge sys_clk_i) begin
      float_q <= ~float_q;
   end
   always @* begin
      bus_o[15:8] = hi_on ? word[15:8] :
         (!dq_oe_n_i ? dq_c_i[15:8] : float_q[15:8]);
      bus_o[7:0] = lo_on ? word[7:0] :
         (!dq_oe_n_i ? dq_c_i[7:0] : float_q[7:0]);
   end
   // ---------------------------------------------------------------
   // Write side
   // ---------------------------------------------------------------
   always @* begin
      if (sel && !we_n_i) begin
         if (!upper_byte_enable_n_i) begin
            mem[addr_i[7:0]][15:8] = bus_o[15:8];
         end
         if (!lower_byte_enable_n_i) begin
            mem[addr_i[7:0]][7:0] = bus_o[7:0];
         end
      end
   end
endmodule : asrc_mem_model

/* File: dv/async_sram_ecc_access_timing_bench.sv */
module async_sram_ecc_access_timing_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PWR = 8;
   logic sys_clk_i, resetn_i, req_i, req_we_i, err_en;
   logic [19:0] req_addr_i, addr_o;
   logic [15:0] req_wdata_i, rdata_o, dq_o, bus;
   logic [1:0] req_be_i;
   logic ready_o, init_done_o, rvalid_o, rerr_o, select_low_n_o;
   logic select_high_o, oe_n_o, we_n_o, ube_n, lbe_n, dq_oe_n_o;
   logic err, mem_drv;
   logic [7:0] err_addr;
   logic [15:0] ref_mem [0:15];
   int n_errors, tests_run, seed, i, n;
   logic [31:0] r;

   asrc_ctrl #(.PWR_CYC(PWR)) uut (.sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i), .req_i(req_i), .req_we_i(req_we_i),
      .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
      .req_be_i(req_be_i), .ready_o(ready_o), .init_done_o(init_done_o),
      .rvalid_o(rvalid_o), .rdata_o(rdata_o), .rerr_o(rerr_o),
      .select_low_n_o(select_low_n_o), .select_high_o(select_high_o),
      .oe_n_o(oe_n_o), .we_n_o(we_n_o), .upper_byte_enable_n_o(ube_n),
      .lower_byte_enable_n_o(lbe_n), .addr_o(addr_o), .dq_o(dq_o),
      .dq_oe_n_o(dq_oe_n_o), .dq_i(bus), .err_i(err));
   asrc_mem_model mem (.sys_clk_i(sys_clk_i),
      .select_low_n_i(select_low_n_o), .select_high_i(select_high_o),
      .oe_n_i(oe_n_o), .we_n_i(we_n_o), .upper_byte_enable_n_i(ube_n),
      .lower_byte_enable_n_i(lbe_n), .addr_i(addr_o), .dq_c_i(dq_o),
      .dq_oe_n_i(dq_oe_n_o), .err_en_i(err_en), .err_addr_i(err_addr),
      .bus_o(bus), .err_o(err), .mem_drv_o(mem_drv));

   // ---------------------------------------------------------------
   // Checking and expectations
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   function automatic logic [15:0] lanes(input logic [1:0] be);
      return {{8{be[1]}}, {8{be[0]}}};
   endfunction : lanes
   function automatic logic [15:0] merge(input logic [15:0] old,
      input logic [15:0] d, input logic [1:0] be);
      return (old & ~lanes(be)) | (d & lanes(be));
   endfunction : merge
   task automatic finish_test();
      $display("Errors %0d, checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // ---------------------------------------------------------------
   // Drivers
   // ---------------------------------------------------------------
   task automatic do_reset();
      resetn_i <= 1'b0;
      repeat (16) @(posedge sys_clk_i);
      check("pins in reset", {select_low_n_o, select_high_o, oe_n_o,
         we_n_o, dq_oe_n_o, ready_o}, 6'b101110);
      resetn_i <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (init_done_o !== 1'b1 && n < 100);
      check("power-up wait", n >= PWR && n < 100, 1);
   endtask : do_reset
   task automatic access(input logic we, input logic [3:0] a,
      input logic [15:0] d, input logic [1:0] be);
      int k;
      @(posedge sys_clk_i);
      req_i <= 1'b1;
      req_we_i <= we;
      req_addr_i <= {16'h0000, a};
      req_wdata_i <= d;
      req_be_i <= be;
      k = 0;
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (ready_o !== 1'b1 && k < 50);
      req_i <= 1'b0;
      check("request taken", k < 50, 1);
      @(negedge sys_clk_i);
      check("address pins", addr_o, {16'h0000, a});
      check("lane pins", {ube_n, lbe_n}, {~be[1], ~be[0]});
      check("drive pins", {dq_oe_n_o, oe_n_o}, {~we, we});
      if (we) begin
         check("write data pins", dq_o, d);
         ref_mem[a] = merge(ref_mem[a], d, be);
      end else begin
         k = 0;
         do begin
            @(posedge sys_clk_i);
            k++;
         end while (rvalid_o !== 1'b1 && k < 30);
         check("read answer", k < 30, 1);
         check("read data", rdata_o & lanes(be),
            ref_mem[a] & lanes(be));
         check("error flag", rerr_o,
            err_en && a == err_addr[3:0]);
      end
   endtask : access

   // Pin monitor: contention, early access, enable overlap
   always @(posedge sys_clk_i) begin
      if (resetn_i) begin
         check("bus contention", mem_drv && !dq_oe_n_o, 0);
         check("early access", !init_done_o && !select_low_n_o, 0);
         check("oe in write", !we_n_o && !oe_n_o, 0);
      end
   end

   initial begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      #200000;
      n_errors++;
      finish_test();
   end

   initial begin
      resetn_i = 1'b0;
      req_i = 1'b0;
      req_we_i = 1'b0;
      req_addr_i = 20'h00000;
      req_wdata_i = 16'h0000;
      req_be_i = 2'h0;
      err_en = 1'b0;
      err_addr = 8'h07;
      n_errors = 0;
      tests_run = 0;
      seed = 33346;
      do_reset();
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         ref_mem[i] = 16'h0000;
         access(1'b1, i[3:0], r[15:0], 2'h3);
      end
      for (i = 0; i < 16; i++) access(1'b0, i[3:0], 16'h0000, 2'h3);
      // Lane-only writes, then a write with no lane enabled
      for (i = 0; i < 3; i++) begin
         access(1'b1, 4'h5, 16'hc3a5 ^ i[15:0], 2'h1 << i);
         access(1'b0, 4'h5, 16'h0000, 2'h3);
      end
      err_en = 1'b1;
      access(1'b0, 4'h7, 16'h0000, 2'h3);
      access(1'b0, 4'h8, 16'h0000, 2'h2);
      for (i = 0; i < 60; i++) begin
         r = $random(seed);
         access(r[20], r[19:16], r[15:0], r[22:21]);
      end
      err_en = 1'b0;
      // Reset in the middle of a read
      @(posedge sys_clk_i);
      req_i <= 1'b1;
      req_we_i <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      req_i <= 1'b0;
      resetn_i <= 1'b0;
      #2;
      check("pins after reset", {select_low_n_o, oe_n_o, dq_oe_n_o},
         3'b111);
      do_reset();
      access(1'b0, 4'h3, 16'h0000, 2'h3);
      finish_test();
   end
endmodule : async_sram_ecc_access_timing_bench

/* File: rtl/asrc_ctrl.sv */
// Operation
// R1: Wait power-up interval before first access
// R2: Space reads by read cycle time
// R3: Memory holds old data after address change
// R4: Memory data valid after select
// R5: Memory data valid after output enable
// R6: Memory floats promptly after output enable off
// R7: Memory floats promptly after deselect
// R8: Memory lane valid after byte enable
// R9: Memory lane floats after byte disable
// R10: Memory powers down after deselect
// R11: Memory float time shorter than drive time
// R12: Write only while enable, select, byte low
// R13: Write data stable before write end
// R14: Address valid at start, stable through end
// R15: Select held low before write end
// R16: Write pulse long enough, covers float plus setup
// R17: Byte enable held low before write end
// R18: Memory floats after write enable falls
// R19: Select means low select low, high high
// R20: Error flag reports corrected single-bit error
// R21: Lower-only write leaves upper lane untouched
// R22: Never drive data while memory drives
// R23: Speed grade parameter, limits rounded up
// R24: Space writes and write-to-read by cycle time
module asrc_ctrl #(
   parameter int ADDR_W = 20,
   parameter bit FAST_GRADE = 1'b1,
   parameter int PWR_CYC = asrc_pkg::PWR_CYC
) (
   input wire logic sys_clk_i, // System clock, 50 MHz
   input wire logic resetn_i, // Async reset, active low
   input wire logic req_i, // Access request
   input wire logic req_we_i, // 1 write, 0 read
   input wire logic [ADDR_W-1:0] req_addr_i, // Word address
   input wire logic [15:0] req_wdata_i, // Write data
   input wire logic [1:0] req_be_i, // Byte enables, bit1 upper
   output logic ready_o, // Request may be taken
   output logic init_done_o, // Power-up wait over
   output logic rvalid_o, // Read data pulse
   output logic [15:0] rdata_o, // Read data
   output logic rerr_o, // Corrected error on read
   output logic select_low_n_o, // Active-low select pin
   output logic select_high_o, // Active-high select pin
   output logic oe_n_o, // Output enable pin, active low
   output logic we_n_o, // Write enable pin, active low
   output logic upper_byte_enable_n_o, // Upper lane enable
   output logic lower_byte_enable_n_o, // Lower lane enable
   output logic [ADDR_W-1:0] addr_o, // Address pins
   output logic [15:0] dq_o, // Data pins, output value
   output logic dq_oe_n_o, // Data pin drive, low drives
   input wire logic [15:0] dq_i, // Data pins, sensed level
   input wire logic err_i // Error flag pin
);
   // ---------------------------------------------------------------
   // Grade-dependent cycle counts
   // ---------------------------------------------------------------
   localparam int RD_CYC = FAST_GRADE ? asrc_pkg::RD_CYC_FAST : // R23
      asrc_pkg::RD_CYC_SLOW;
   localparam int RC_CYC = FAST_GRADE ? asrc_pkg::RC_CYC_FAST :
      asrc_pkg::RC_CYC_SLOW;
   localparam int HZ_CYC = FAST_GRADE ? asrc_pkg::HZ_CYC_FAST :
      asrc_pkg::HZ_CYC_SLOW;
   localparam int PWE_CYC = FAST_GRADE ? asrc_pkg::PWE_CYC_FAST :
      asrc_pkg::PWE_CYC_SLOW;
   localparam int WC_CYC = FAST_GRADE ? asrc_pkg::WC_CYC_FAST :
      asrc_pkg::WC_CYC_SLOW;
   localparam int RD_HOLD = ((RD_CYC > RC_CYC) ? RD_CYC : RC_CYC)
      + asrc_pkg::SYNC_LAT;
   localparam int GAP_CYC = (WC_CYC > HZ_CYC) ? WC_CYC : HZ_CYC;

   if (PWR_CYC < 1 || PWR_CYC >= 2**asrc_pkg::CNT_W
       || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_param
      $error("asrc_ctrl: PWR_CYC or ADDR_W out of range");
   end

   asrc_pkg::asrc_state_t state_reg;
   logic [asrc_pkg::CNT_W-1:0] cnt_reg;
   logic [16:0] pin_sync;
   logic take;
   logic cnt_zero;

   assign take = req_i && ready_o;
   assign cnt_zero = (cnt_reg == '0);

   // ---------------------------------------------------------------
   // Data and error pin synchroniser
   // ---------------------------------------------------------------
   asrc_sync #(
      .WIDTH(17)
   ) u_sync (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .pin_i({err_i, dq_i}),
      .sync_o(pin_sync)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= asrc_pkg::ST_POWER;
         cnt_reg <= asrc_pkg::CNT_W'(PWR_CYC - 1);
      end else begin
         case (state_reg)
            asrc_pkg::ST_POWER: begin
               if (cnt_zero) begin // R1
                  state_reg <= asrc_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            asrc_pkg::ST_IDLE: begin
               if (take && req_we_i) begin
                  state_reg <= asrc_pkg::ST_WSETUP;
               end else if (take) begin
                  state_reg <= asrc_pkg::ST_READ;
                  cnt_reg <= asrc_pkg::CNT_W'(RD_HOLD - 1); // R2
               end
            end
            asrc_pkg::ST_READ: begin
               if (cnt_zero) begin
                  state_reg <= asrc_pkg::ST_GAP;
                  cnt_reg <= asrc_pkg::CNT_W'(GAP_CYC - 1);
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            asrc_pkg::ST_WSETUP: begin
               state_reg <= asrc_pkg::ST_WPULSE;
               // Pulse length is counted the same with or without a lane
               cnt_reg <= asrc_pkg::CNT_W'(PWE_CYC - 1); // R16
            end
            asrc_pkg::ST_WPULSE: begin
               if (cnt_zero) begin
                  state_reg <= asrc_pkg::ST_WEND;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            asrc_pkg::ST_WEND: begin
               state_reg <= asrc_pkg::ST_GAP;
               cnt_reg <= asrc_pkg::CNT_W'(GAP_CYC - 1); // R24
            end
            asrc_pkg::ST_GAP: begin
               if (cnt_zero) begin
                  state_reg <= asrc_pkg::ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;
               end
            end
            default: begin
               state_reg <= asrc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // User-side handshake and status
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ready_o <= 1'b0;
         init_done_o <= 1'b0;
      end else begin
         ready_o <= (state_reg == asrc_pkg::ST_POWER && cnt_zero)
            || (state_reg == asrc_pkg::ST_GAP && cnt_zero)
            || (state_reg == asrc_pkg::ST_IDLE && !take);
         if (state_reg == asrc_pkg::ST_POWER && cnt_zero) begin
            init_done_o <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Memory control pins
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         select_low_n_o <= 1'b1;
         select_high_o <= 1'b0;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
         upper_byte_enable_n_o <= 1'b1;
         lower_byte_enable_n_o <= 1'b1;
         addr_o <= '0;
      end else if (take) begin
         select_low_n_o <= 1'b0; // R19 R15
         select_high_o <= 1'b1;
         oe_n_o <= req_we_i; // R22
         upper_byte_enable_n_o <= !req_be_i[1]; // R21 R17
         lower_byte_enable_n_o <= !req_be_i[0];
         addr_o <= req_addr_i; // R14
      end else if (state_reg == asrc_pkg::ST_WSETUP) begin
         // No lane enabled: no write, so write enable stays high
         we_n_o <= upper_byte_enable_n_o && lower_byte_enable_n_o; // R12
      end else if (state_reg == asrc_pkg::ST_WPULSE && cnt_zero) begin
         we_n_o <= 1'b1;
      end else if (state_reg == asrc_pkg::ST_WEND
                   || (state_reg == asrc_pkg::ST_READ && cnt_zero)) begin
         select_low_n_o <= 1'b1;
         select_high_o <= 1'b0;
         oe_n_o <= 1'b1;
         upper_byte_enable_n_o <= 1'b1;
         lower_byte_enable_n_o <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Write data drive
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dq_o <= '0;
         dq_oe_n_o <= 1'b1;
      end else if (take && req_we_i) begin
         dq_o <= req_wdata_i; // R13
         dq_oe_n_o <= 1'b0;
      end else if (state_reg == asrc_pkg::ST_WEND) begin
         dq_oe_n_o <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Read capture
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rerr_o <= 1'b0;
      end else begin
         rvalid_o <= state_reg == asrc_pkg::ST_READ && cnt_zero;
         if (state_reg == asrc_pkg::ST_READ && cnt_zero) begin
            rdata_o <= pin_sync[15:0];
            rerr_o <= pin_sync[16]; // R20
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   a_power_wait_idle: assert property ( // R1
      !init_done_o |-> select_low_n_o && we_n_o && !ready_o)
      else $error("access before power-up wait");
   a_read_hold_len: assert property ( // R2
      rvalid_o |-> $past(!oe_n_o, 1) && $past(!oe_n_o, RD_HOLD))
      else $error("read strobe shorter than read cycle");
   a_select_pair: assert property ( // R19
      select_high_o == !select_low_n_o)
      else $error("select pins disagree");
   a_write_overlap: assert property ( // R12
      !we_n_o |-> !select_low_n_o && !dq_oe_n_o
         && !(upper_byte_enable_n_o && lower_byte_enable_n_o))
      else $error("write without select, lane or data");
   a_write_data_setup: assert property ( // R13
      $rose(we_n_o) |-> $stable(dq_o) && $past(!dq_oe_n_o, 1)
         && $past(dq_o, 1) == $past(dq_o, 2))
      else $error("write data not stable around write end");
   a_write_addr_hold: assert property ( // R14
      $fell(we_n_o) |-> $stable(addr_o) ##1 $stable(addr_o))
      else $error("address moved during write");
   a_write_pulse_len: assert property ( // R16 R15
      $rose(we_n_o) |-> $past(!we_n_o, PWE_CYC)
         && $past(!select_low_n_o, PWE_CYC))
      else $error("write pulse or select too short");
   a_no_contention: assert property ( // R22
      !dq_oe_n_o |-> oe_n_o && $past(oe_n_o))
      else $error("data driven while memory may drive");
   a_access_gap: assert property ( // R24
      $rose(select_low_n_o) |-> !ready_o ##1 select_low_n_o)
      else $error("no gap after access");
   a_lower_only: assert property ( // R21
      $rose(we_n_o) && upper_byte_enable_n_o |-> $past(
         upper_byte_enable_n_o, 1))
      else $error("upper lane enabled in lower-only write");
   a_lane_before_end: assert property ( // R17
      $rose(we_n_o) |-> $past(!(upper_byte_enable_n_o
         && lower_byte_enable_n_o), PWE_CYC))
      else $error("byte enable not held to write end");

   c_read: cover property (rvalid_o);
   c_write: cover property ($rose(we_n_o));
   c_lower_write: cover property (
      !we_n_o && upper_byte_enable_n_o && !lower_byte_enable_n_o);
   c_err_read: cover property (rvalid_o && rerr_o);
endmodule : asrc_ctrl

/* File: rtl/asrc_pkg.sv */
package asrc_pkg;
   // ---------------------------------------------------------------
   // Clock and timing figures (picoseconds, microseconds)
   // ---------------------------------------------------------------
   localparam int CLK_PS = 20000;
   localparam int T_POWER_US = 100;
   localparam int T_RC_FAST_PS = 10000;
   localparam int T_RC_SLOW_PS = 15000;
   localparam int T_AA_FAST_PS = 10000;
   localparam int T_AA_SLOW_PS = 15000;
   localparam int T_HZOE_FAST_PS = 5000;
   localparam int T_HZOE_SLOW_PS = 8000;
   localparam int T_PWE_FAST_PS = 7000;
   localparam int T_PWE_SLOW_PS = 12000;
   localparam int T_SD_FAST_PS = 5000;
   localparam int T_SD_SLOW_PS = 8000;
   localparam int T_HZWE_FAST_PS = 5000;
   localparam int T_HZWE_SLOW_PS = 8000;
   localparam int T_WC_FAST_PS = 10000;
   localparam int T_WC_SLOW_PS = 15000;

   // ---------------------------------------------------------------
   // Cycle counts, all rounded up except PWR_CYC, which is truncated
   // ---------------------------------------------------------------
   localparam int PWR_CYC = T_POWER_US * 1000000 / CLK_PS;
   localparam int RD_CYC_FAST = (T_AA_FAST_PS + CLK_PS - 1) / CLK_PS;
   localparam int RD_CYC_SLOW = (T_AA_SLOW_PS + CLK_PS - 1) / CLK_PS;
   localparam int RC_CYC_FAST = (T_RC_FAST_PS + CLK_PS - 1) / CLK_PS;
   localparam int RC_CYC_SLOW = (T_RC_SLOW_PS + CLK_PS - 1) / CLK_PS;
   localparam int HZ_CYC_FAST = (T_HZOE_FAST_PS + CLK_PS - 1) / CLK_PS;
   localparam int HZ_CYC_SLOW = (T_HZOE_SLOW_PS + CLK_PS - 1) / CLK_PS;
   localparam int PWE_MIN_FAST = (T_HZWE_FAST_PS + T_SD_FAST_PS
      > T_PWE_FAST_PS) ? T_HZWE_FAST_PS + T_SD_FAST_PS : T_PWE_FAST_PS;
   localparam int PWE_MIN_SLOW = (T_HZWE_SLOW_PS + T_SD_SLOW_PS
      > T_PWE_SLOW_PS) ? T_HZWE_SLOW_PS + T_SD_SLOW_PS : T_PWE_SLOW_PS;
   localparam int PWE_CYC_FAST = (PWE_MIN_FAST + CLK_PS - 1) / CLK_PS;
   localparam int PWE_CYC_SLOW = (PWE_MIN_SLOW + CLK_PS - 1) / CLK_PS;
   localparam int WC_CYC_FAST = (T_WC_FAST_PS + CLK_PS - 1) / CLK_PS;
   localparam int WC_CYC_SLOW = (T_WC_SLOW_PS + CLK_PS - 1) / CLK_PS;
   // Edges from a pin change to the filtered input register
   localparam int SYNC_LAT = 4;
   localparam int CNT_W = 16;
   localparam int DATA_W = 16;

   typedef enum logic [2:0] {
      ST_POWER, ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_WEND, ST_GAP
   } asrc_state_t;
endpackage : asrc_pkg

/* File: rtl/asrc_sync.sv */
module asrc_sync #(
   parameter int WIDTH = 17
) (
   input wire logic sys_clk_i, // System clock
   input wire logic resetn_i, // Async reset, active low
   input wire logic [WIDTH-1:0] pin_i, // Asynchronous pin levels
   output logic [WIDTH-1:0] sync_o // Filtered, synchronised levels
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] out_reg;

   if (WIDTH < 1) begin : g_bad_width
      $error("asrc_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit takes its new level only once stages two and three agree
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            out_reg[i] <= 1'b0;
         end else if (s2_reg[i] == s3_reg[i]) begin
            out_reg[i] <= s3_reg[i];
         end
      end
   end

   assign sync_o = out_reg;
endmodule : asrc_sync
